// ### src/usu_regs.svh
// Purpose: Register offsets, field positions and reset values of the serial shift unit
// Assumes: Word-wide Wishbone slave; byte address is four times the register index
// Notes: Constants only, no logic
//
// Notes on behaviour
// - Data register access hits live shifter
// - Write beats simultaneous shift, no shift
// - Left shift on selected clock event
// - Inputs still work with outputs disabled
// - Data pin driven from MSB via latch
// - Latch half-transparent external, open internal
// - Open latch passes new MSB immediately
// - Pin driven only when direction set
// - Start flag: start condition or clock edge
// - Start flag cleared by one; releases hold
// - Start request needs flag, enable, global
// - Overflow flag on wrap fifteen to zero
// - Overflow cleared by one or buffer read
// - Overflow request wakes only from idle
// - Stop flag in two-wire, no request
// - Collision bit: MSB differs from pin
// - Counter readable, writable, counts events
// - Toggle strobe clocks counter when selected
// - Counter clocks externally in mode zero
// - Enable with pending flag requests at once
// - Wire mode shapes outputs and start/stop detection
// - Wire mode encoding zero to three
// - Strobe select shifts and counts once
`ifndef USU_REGS_SVH
`define USU_REGS_SVH

// Register indices (byte address = index * 4)
`define IDX_SERIAL_CONTROL        6'h0D
`define IDX_SERIAL_STATUS         6'h0E
`define IDX_SERIAL_SHIFT_DATA     6'h0F
`define IDX_SERIAL_RECEIVE_BUFFER 6'h10

// Status register fields
`define ST_START_BIT     7
`define ST_OVERFLOW_BIT  6
`define ST_STOP_BIT      5
`define ST_COLLISION_BIT 4

// Control register fields
`define CT_START_IE_BIT  7
`define CT_OVF_IE_BIT    6
`define CT_WM_HI         5
`define CT_WM_LO         4
`define CT_CS_HI         3
`define CT_CS_LO         2
`define CT_STROBE_BIT    1
`define CT_TOGGLE_BIT    0

// Reset values and counter limit
`define RESET_BYTE       8'h00
`define COUNTER_MAX      4'hF

`endif

// ### src/usu_pkg.sv
// Purpose: Types shared by the serial shift unit
// Assumes: Constants live in usu_regs.svh
// Notes: Whole unit state is one packed struct
package usu_pkg;

	// Wire mode encoding
	typedef enum logic [1:0] {
		WM_OFF       = 2'h0,
		WM_THREE     = 2'h1,
		WM_TWO       = 2'h2,
		WM_TWO_HOLD  = 2'h3
	} wire_mode_type;

	// Complete register state of the unit
	typedef struct packed {
		logic [7:0]    shift;
		logic [7:0]    rx_buf;
		logic [3:0]    cnt;
		logic          start_flag;
		logic          overflow_flag;
		logic          stop_flag;
		logic          start_ie;
		logic          ovf_ie;
		wire_mode_type wm;
		logic [1:0]    cs;
		logic          strobe_sel;
		logic          out_latch;
		logic          start_hold;
		logic          sck_s1;
		logic          sck_s2;
		logic          sck_s3;
		logic          sdi_s1;
		logic          sdi_s2;
		logic          sdi_s3;
		logic          ack;
		logic [7:0]    rdata;
		logic          toggle;
	} state_type;

endpackage

// ### src/universal_serial_shift_unit.sv
// Purpose: Universal serial shift unit with Wishbone register access
// Assumes: ref_clk 20 MHz, pins synchronised here, port/direction bits supplied from outside
// Notes: Open-drain pins are shown as output enables; the line is driven low when enabled
`timescale 1ns/1ps
`default_nettype none
`include "usu_regs.svh"

module universal_serial_shift_unit (
	input  wire logic        ref_clk,        // System clock
	input  wire logic        rst_n,          // Synchronous reset, active low
	input  wire logic        cyc_i,          // Wishbone cycle
	input  wire logic        stb_i,          // Wishbone strobe
	input  wire logic        we_i,           // Wishbone write enable
	input  wire logic [7:0]  adr_i,          // Wishbone byte address
	input  wire logic [3:0]  sel_i,          // Wishbone byte select
	input  wire logic [31:0] dat_i,          // Wishbone write data
	output logic      [31:0] dat_o,          // Wishbone read data
	output logic             ack_o,          // Wishbone acknowledge
	input  wire logic        serial_in_pin,  // Data input, also SDA line level
	input  wire logic        serial_clock_pin, // Clock input, also SCL line level
	input  wire logic        timer_match,    // Timer compare match pulse
	input  wire logic        global_irq_enable, // Processor global enable
	input  wire logic        idle_sleep,     // Processor is in idle sleep
	input  wire logic        data_dir,       // Direction bit of the data pin
	input  wire logic        data_port,      // Port bit of the data pin
	input  wire logic        clock_dir,      // Direction bit of the clock pin
	input  wire logic        clock_port,     // Port bit of the clock pin
	output logic             data_out,       // Three-wire data output level
	output logic             data_oe,        // Three-wire data output enable
	output logic             sda_out,        // SDA output level, always low
	output logic             sda_oe,         // SDA pulled low when high
	output logic             scl_out,        // SCL output level, always low
	output logic             scl_oe,         // SCL pulled low when high
	output logic             clock_toggle,   // Pulse asking port logic to flip clock bit
	output logic             start_irq,      // Start condition request
	output logic             overflow_irq,   // Counter overflow request
	output logic             wake_request    // Wake the processor
);
	import usu_pkg::*;

	// Whole unit state lives in one struct: one process fills the copy, one registers it
	state_type r_reg;   // Registered state
	state_type r_next;  // Next state

	// Decoded strobes and events, combinational from the registers, the bus and the timer match
	logic [5:0] idx;         // Register index from byte address
	logic       take;        // Request taken at this edge
	logic       wr;          // Write of the low byte taken
	logic       rd_buf;      // Receive buffer read taken
	logic       wr_ctl;      // Control write
	logic       wr_st;       // Status write
	logic       wr_data;     // Shift data write
	logic       scl_rise;    // Clock pin rising edge
	logic       scl_fall;    // Clock pin falling edge
	logic       ext_edge;    // Either clock edge
	logic       sw_strobe;   // Software shift strobe
	logic       tog;         // Toggle strobe written
	logic       shift_ev;    // Shift event
	logic       cnt_ev;      // Count event
	logic       wrap;        // Counter wraps to zero
	logic       two_wire;    // Either two-wire mode
	logic       start_det;   // Start condition seen
	logic       stop_det;    // Stop condition seen
	logic       transparent; // Output latch open
	logic       out_bit;     // Latched MSB toward the pin
	logic       collision;   // MSB differs from SDA level

	// Address decode and handshake terms
	assign idx     = adr_i[7:2];
	// A request acts only at the edge where ack is high, so nothing acts twice
	assign take    = cyc_i & stb_i & r_reg.ack;
	assign wr      = take & we_i & sel_i[0];
	assign wr_ctl  = wr & (idx == `IDX_SERIAL_CONTROL);
	assign wr_st   = wr & (idx == `IDX_SERIAL_STATUS);
	assign wr_data = wr & (idx == `IDX_SERIAL_SHIFT_DATA);
	assign rd_buf  = take & ~we_i & (idx == `IDX_SERIAL_RECEIVE_BUFFER);

	// Edges of the synchronised clock pin; inputs keep their function in every mode
	assign scl_rise = r_reg.sck_s2 & ~r_reg.sck_s3;
	assign scl_fall = ~r_reg.sck_s2 & r_reg.sck_s3;
	assign ext_edge = scl_rise | scl_fall;
	assign two_wire = r_reg.wm[1];

	// Start: SDA falls while SCL high; stop: SDA rises while SCL high
	assign start_det = two_wire & r_reg.sck_s2 & ~r_reg.sdi_s2 & r_reg.sdi_s3;
	assign stop_det  = two_wire & r_reg.sck_s2 & r_reg.sdi_s2 & ~r_reg.sdi_s3;

	// Strobes come from the byte being written; the strobe fires only if that byte also names the software source
	// Limitation: the clock source itself is the stored one, so set it in an earlier write
	assign sw_strobe = wr_ctl & dat_i[`CT_STROBE_BIT] & (dat_i[`CT_CS_HI:`CT_CS_LO] == 2'h0);
	assign tog       = wr_ctl & dat_i[`CT_TOGGLE_BIT];

	// Clock source selection for shifter and counter
	always_comb begin
		case (r_reg.cs)
			2'h0: begin
				shift_ev = sw_strobe;
				cnt_ev   = sw_strobe;
			end
			2'h1: begin
				shift_ev = timer_match;
				cnt_ev   = timer_match;
			end
			default: begin
				// External pin edges clock even with outputs off
				shift_ev = r_reg.cs[0] ? scl_fall : scl_rise;
				cnt_ev   = r_reg.strobe_sel ? tog : ext_edge;
			end
		endcase
	end

	// Wrap is decided before the increment so flag set and buffer copy see one event
	assign wrap = cnt_ev & (r_reg.cnt == `COUNTER_MAX);

	// Latch follows MSB in first half of external clock cycle, always when internal
	assign transparent = ~r_reg.cs[1] | (r_reg.cs[0] ? r_reg.sck_s2 : ~r_reg.sck_s2);
	assign out_bit     = transparent ? r_reg.shift[7] : r_reg.out_latch;
	// Collision only means something in two-wire mode; software masks it otherwise
	assign collision   = r_reg.shift[7] ^ r_reg.sdi_s2;

	// Next-state logic for the whole unit
	always_comb begin
		r_next = r_reg;
		// Two-stage synchronisers, then one history stage for edges
		r_next.sck_s1 = serial_clock_pin;
		r_next.sck_s2 = r_reg.sck_s1;
		r_next.sck_s3 = r_reg.sck_s2;
		r_next.sdi_s1 = serial_in_pin;
		r_next.sdi_s2 = r_reg.sdi_s1;
		r_next.sdi_s3 = r_reg.sdi_s2;
		r_next.out_latch = out_bit;
		r_next.toggle = tog;

		// Bus answer one cycle after request, dropped the cycle after
		// The ack is a registered pulse, so it never stands two cycles
		r_next.ack = cyc_i & stb_i & ~r_reg.ack;
		r_next.rdata = `RESET_BYTE;
		// Read data is captured at the request edge and stands with ack
		if (cyc_i & stb_i & ~r_reg.ack) begin
			case (idx)
				`IDX_SERIAL_CONTROL: begin
					r_next.rdata = {r_reg.start_ie, r_reg.ovf_ie, r_reg.wm, r_reg.cs,
						r_reg.strobe_sel & r_reg.cs[1], 1'b0};
				end
				`IDX_SERIAL_STATUS: begin
					r_next.rdata = {r_reg.start_flag, r_reg.overflow_flag, r_reg.stop_flag,
						collision, r_reg.cnt};
				end
				`IDX_SERIAL_SHIFT_DATA: begin
					r_next.rdata = r_reg.shift;
				end
				`IDX_SERIAL_RECEIVE_BUFFER: begin
					r_next.rdata = r_reg.rx_buf;
				end
				default: begin
					r_next.rdata = `RESET_BYTE; // Unmapped reads as zero
				end
			endcase
		end

		// Control register
		if (wr_ctl) begin
			r_next.start_ie   = dat_i[`CT_START_IE_BIT];
			r_next.ovf_ie     = dat_i[`CT_OVF_IE_BIT];
			r_next.wm         = wire_mode_type'(dat_i[`CT_WM_HI:`CT_WM_LO]);
			r_next.cs         = dat_i[`CT_CS_HI:`CT_CS_LO];
			r_next.strobe_sel = dat_i[`CT_STROBE_BIT];
		end

		// Shifter: a software write wins over a coincident shift
		if (wr_data) begin
			r_next.shift = dat_i[7:0];
		end else if (shift_ev) begin
			r_next.shift = {r_reg.shift[6:0], r_reg.sdi_s2};
		end

		// Counter: software write wins over a coincident count
		if (wr_st) begin
			r_next.cnt = dat_i[3:0];
		end else if (cnt_ev) begin
			r_next.cnt = r_reg.cnt + 4'h1;
		end

		// Finished word goes to the receive buffer
		if (wrap) begin
			r_next.rx_buf = r_next.shift;
		end

		// Overflow flag: clear by one or buffer read, set wins
		// A buffer read and a wrap in one cycle leave the flag set
		if ((wr_st & dat_i[`ST_OVERFLOW_BIT]) | rd_buf) begin
			r_next.overflow_flag = 1'b0;
		end
		if (wrap) begin
			r_next.overflow_flag = 1'b1;
		end

		// Start flag: cleared only by writing one, which also frees the hold
		if (wr_st & dat_i[`ST_START_BIT]) begin
			r_next.start_flag = 1'b0;
			r_next.start_hold = 1'b0;
		end
		if (start_det | (~two_wire & r_reg.cs[1] & ~r_reg.strobe_sel & ext_edge)) begin
			r_next.start_flag = 1'b1;
		end
		// Hold engages once master pulls SCL low after the start
		if (two_wire & r_reg.start_flag & scl_fall & ~(wr_st & dat_i[`ST_START_BIT])) begin
			r_next.start_hold = 1'b1;
		end
		// Outside two-wire mode there is no clock line to hold
		if (~two_wire) begin
			r_next.start_hold = 1'b0;
		end

		// Stop flag, set wins over clear
		if (wr_st & dat_i[`ST_STOP_BIT]) begin
			r_next.stop_flag = 1'b0;
		end
		if (stop_det) begin
			r_next.stop_flag = 1'b1;
		end
	end

	// State register
	// Synchronous reset clears every register, synchronisers included
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	// Bus outputs
	// Upper bytes read as zero; each register is one byte wide
	assign dat_o = {24'h00_0000, r_reg.rdata};
	assign ack_o = r_reg.ack;

	// Pin drivers; mode shapes the outputs here and the start/stop detection above
	// Open-drain lines: an enable pulls the line low, no enable releases it
	assign data_out = out_bit;
	assign data_oe  = data_dir & (r_reg.wm == WM_THREE);
	assign sda_out  = 1'b0;
	assign sda_oe   = data_dir & two_wire & (~out_bit | ~data_port);
	assign scl_out  = 1'b0;
	// Overflow hold only in the holding two-wire mode
	assign scl_oe   = clock_dir & two_wire & (~clock_port | r_reg.start_hold |
		((r_reg.wm == WM_TWO_HOLD) & r_reg.overflow_flag));
	assign clock_toggle = r_reg.toggle;

	// Requests are plain levels, so a late enable fires at once
	assign start_irq    = r_reg.start_flag & r_reg.start_ie & global_irq_enable;
	assign overflow_irq = r_reg.overflow_flag & r_reg.ovf_ie & global_irq_enable;
	assign wake_request = start_irq | (overflow_irq & idle_sleep);

	// Checks
	// Assertions are gathered here after the logic they guard; all run on the system clock
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	AST_OVF_SET: assert property (wrap |=> r_reg.overflow_flag
		&& (r_reg.cnt == 4'h0 || $past(wr_st)))
		else $error("overflow flag not set on counter wrap");
	AST_BUF_COPY: assert property (wrap && !wr_data |=> r_reg.rx_buf == r_reg.shift)
		else $error("receive buffer not loaded on wrap");
	AST_WRITE_WINS: assert property (wr_data |=> r_reg.shift == $past(dat_i[7:0]))
		else $error("shift data write lost");
	AST_SHIFT_LEFT: assert property (shift_ev && !wr_data |=>
		r_reg.shift == {$past(r_reg.shift[6:0]), $past(r_reg.sdi_s2)})
		else $error("shift not a left shift of input");
	AST_CNT_INC: assert property (cnt_ev && !wr_st |=> r_reg.cnt == $past(r_reg.cnt) + 4'h1)
		else $error("counter did not advance");
	AST_NO_DRIVE: assert property (!data_dir |-> !data_oe && !sda_oe)
		else $error("data pin driven without direction bit");
	AST_START_NOW: assert property ($rose(r_reg.start_ie) && r_reg.start_flag
		&& global_irq_enable |-> start_irq)
		else $error("pending start request not raised");
	AST_OVF_WAKE: assert property (overflow_irq && !idle_sleep && !start_irq |-> !wake_request)
		else $error("overflow woke from deep sleep");
	AST_STOP_FLAG: assert property (stop_det && !(wr_st && dat_i[`ST_STOP_BIT]) |=>
		r_reg.stop_flag ##0 !$past(start_irq && !r_reg.start_flag))
		else $error("stop flag not set");
	AST_BUF_READ_CLR: assert property (rd_buf && !wrap |=> !r_reg.overflow_flag ##1 ack_o == 1'b0)
		else $error("buffer read did not clear overflow");
	AST_START_EDGE: assert property (!two_wire && r_reg.cs == 2'h2 && !r_reg.strobe_sel
		&& ext_edge |=> r_reg.start_flag)
		else $error("clock edge did not set start flag");
	AST_SW_STROBE: assert property (sw_strobe && r_reg.cs == 2'h0 && !wr_st |=>
		r_reg.cnt == $past(r_reg.cnt) + 4'h1)
		else $error("software strobe did not count");

	// Requests: start wakes from any sleep, stop flag never asks for one
	AST_START_WAKE: assert property (start_irq |-> wake_request)
		else $error("start request did not wake the processor");
	AST_STOP_QUIET: assert property (r_reg.stop_flag && !r_reg.start_flag
		&& !r_reg.overflow_flag |-> !start_irq && !overflow_irq && !wake_request)
		else $error("stop flag raised a request");
	AST_OVF_IRQ: assert property (r_reg.overflow_flag && r_reg.ovf_ie
		&& global_irq_enable |-> overflow_irq)
		else $error("pending overflow request not raised");

	// Flags: start set by a start condition, start and overflow cleared only by software
	AST_START_COND: assert property (start_det |=> r_reg.start_flag)
		else $error("start condition did not set the flag");
	AST_START_STICKY: assert property (r_reg.start_flag
		&& !(wr_st && dat_i[`ST_START_BIT]) |=> r_reg.start_flag)
		else $error("start flag dropped without a clear");
	AST_START_CLR: assert property (wr_st && dat_i[`ST_START_BIT]
		&& !start_det && !ext_edge |=> !r_reg.start_flag && !r_reg.start_hold)
		else $error("start flag or clock hold not released");
	AST_OVF_STICKY: assert property (r_reg.overflow_flag && !wr_st && !rd_buf
		|=> r_reg.overflow_flag)
		else $error("overflow flag dropped without a clear");

	// Counter clocks: toggle strobe when selected, both pin edges otherwise
	AST_TOG_COUNT: assert property (r_reg.cs[1] && r_reg.strobe_sel && tog
		|=> r_reg.cnt == $past(r_reg.cnt) + 4'h1)
		else $error("toggle strobe did not count");
	AST_EXT_COUNT: assert property (r_reg.cs[1] && !r_reg.strobe_sel && ext_edge
		&& !wr_st |=> r_reg.cnt == $past(r_reg.cnt) + 4'h1)
		else $error("pin edge did not count");

	// Output latch: open passes the MSB at once, closed keeps its level
	AST_LATCH_OPEN: assert property (transparent |-> data_out == r_reg.shift[7])
		else $error("open latch did not pass the new MSB");
	AST_LATCH_HOLD: assert property (!transparent |-> data_out == r_reg.out_latch)
		else $error("closed latch let the output change");
	AST_INT_OPEN: assert property (!r_reg.cs[1] |-> transparent)
		else $error("latch closed with an internal clock");

	// Pin enables follow the wire mode, the direction bits and the overflow and start holds on the clock line
	AST_MODE_OE: assert property (r_reg.wm != WM_THREE |-> !data_oe)
		else $error("data output enabled outside three-wire mode");
	AST_OFF_QUIET: assert property (r_reg.wm == WM_OFF
		|-> !sda_oe && !scl_oe && !data_oe)
		else $error("line driven with outputs disabled");
	AST_OVF_HOLD: assert property (clock_dir && r_reg.wm == WM_TWO_HOLD
		&& r_reg.overflow_flag |-> scl_oe)
		else $error("clock line not held after overflow");
	AST_START_HOLD: assert property (clock_dir && two_wire && r_reg.start_hold
		|-> scl_oe)
		else $error("clock line not held after start");

	// Bus: one acknowledge per request, never two cycles in a row
	AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
		else $error("acknowledge stood for two cycles");

endmodule
`default_nettype wire

// ### verification/serial_master_model.sv
// Purpose: Behavioural serial master that clocks one byte into the unit
// Assumes: Positive-edge sampling at the unit, clock idles low between frames
// Notes: Link clock period 400 ns, free of any phase tie to ref_clk
`timescale 1ns/1ps
`default_nettype none

module serial_master_model (
	input  wire logic       go,      // Rising edge starts one frame
	input  wire logic [7:0] tx_byte, // Byte to send
	output logic            sck,     // Link clock, still outside frames
	output logic            sdi,     // Data line towards the unit
	output logic            done     // High once the frame has ended
);
	// Idle level: data shows the inverse of an assumed last zero
	initial begin
		sck = 1'b0;
		sdi = 1'b1;
		done = 1'b0;
	end

	// One frame: data changes on the falling half so the rise samples it
	always @(posedge go) begin
		done = 1'b0;
		#13;
		for (int i = 7; i >= 0; i--) begin
			sdi = tx_byte[i];
			#200;
			sck = 1'b1;
			#200;
			sck = 1'b0;
		end
		// Released line must not keep the last bit
		sdi = ~sdi;
		done = 1'b1;
	end
endmodule

`default_nettype wire

// ### verification/universal_serial_shift_unit_test.sv
// Purpose: Self-checking bench for the serial shift unit over Wishbone
// Assumes: One-cycle ack, byte address is index times four
// Notes: Collision bit masked except in the reset and two-wire checks
`timescale 1ns/1ps
`default_nettype none

module universal_serial_shift_unit_test;
	import usu_pkg::*;
	localparam logic [7:0] A_CTL = 8'h34; // Control
	localparam logic [7:0] A_ST  = 8'h38; // Status
	localparam logic [7:0] A_SD  = 8'h3C; // Shift data
	localparam logic [7:0] A_RB  = 8'h40; // Receive buffer
	logic        ref_clk = 1'b0;          // System clock
	logic        rst_n = 1'b0;            // Reset, active low
	logic        cyc = 1'b0;              // Bus cycle
	logic        stb = 1'b0;              // Bus strobe
	logic        we = 1'b0;               // Bus direction
	logic [7:0]  adr = 8'h00;             // Bus address
	logic [31:0] dat = 32'h0000_0000;     // Bus write data
	logic [31:0] dat_o;                   // Bus read data
	logic        ack_o;                   // Bus acknowledge
	logic        sck, sdi, done;          // Link signals
	logic        go = 1'b0;               // Frame start
	logic        tm = 1'b0;               // Timer match
	logic        gie = 1'b0, idle = 1'b0; // Processor state
	logic        ddir = 1'b0, dport = 1'b0, cdir = 1'b0, cport = 1'b0;
	logic        data_out, data_oe, sda_oe, scl_oe, ctog, sirq, oirq, wake;
	logic        seen_tog = 1'b0;         // Toggle pulse caught
	int          miscompares = 0;
	int          tests_run = 0;
	int          cycles = 0;

	universal_serial_shift_unit u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o),
		.ack_o(ack_o), .serial_in_pin(sdi), .serial_clock_pin(sck), .timer_match(tm),
		.global_irq_enable(gie), .idle_sleep(idle), .data_dir(ddir), .data_port(dport),
		.clock_dir(cdir), .clock_port(cport), .data_out(data_out), .data_oe(data_oe),
		.sda_out(), .sda_oe(sda_oe), .scl_out(), .scl_oe(scl_oe), .clock_toggle(ctog),
		.start_irq(sirq), .overflow_irq(oirq), .wake_request(wake));

	serial_master_model u_master (.go(go), .tx_byte(8'h3C), .sck(sck), .sdi(sdi), .done(done));

	// 50 ns clock
	initial begin
		forever #25 ref_clk = ~ref_clk;
	end

	// Hang guard and toggle-pulse catcher; a pulse lasts one cycle only
	always @(posedge ref_clk) begin
		cycles++;
		if (ctog === 1'b1) seen_tog <= 1'b1;
		if (cycles == 5000) begin
			miscompares++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t byte got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t bit got %b expected %b", $time, got, exp);
		end
	endtask

	// Classic single cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h00_0000, d};
		do @(posedge ref_clk); while (ack_o !== 1'b1);
		q = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		logic [7:0] q;
		wb(1'b0, a, 8'h00, q);
		chk_byte(q & m, e);
	endtask

	// Lets the edge's updates land before combinational outputs are looked at
	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask

	initial begin
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(A_ST, 8'h00, 8'hFF);
		rd(A_RB, 8'h00, 8'hFF);
		rd(8'h7C, 8'h00, 8'hFF);
		$display("test reset done");
		// Three-wire, software strobe source, data pin enabled
		ddir <= 1'b1;
		wr(A_CTL, 8'h10);
		wr(A_SD, 8'hA5);
		rd(A_SD, 8'hA5, 8'hFF);
		tick();
		chk_bit(data_out, 1'b1);
		chk_bit(data_oe, 1'b1);
		ddir <= 1'b0;
		tick();
		chk_bit(data_oe, 1'b0);
		wr(A_CTL, 8'h12);
		rd(A_SD, 8'h4B, 8'hFF);
		rd(A_ST, 8'h01, 8'hEF);
		$display("test strobe done");
		// Counter preset to its top, one strobe wraps it
		wr(A_ST, 8'h0F);
		wr(A_CTL, 8'h12);
		rd(A_ST, 8'h40, 8'hEF);
		gie <= 1'b1;
		idle <= 1'b1;
		wr(A_CTL, 8'h50);
		tick();
		chk_bit(oirq, 1'b1);
		chk_bit(wake, 1'b1);
		idle <= 1'b0;
		tick();
		chk_bit(wake, 1'b0);
		rd(A_RB, 8'h97, 8'hFF);
		rd(A_ST, 8'h00, 8'hEF);
		$display("test overflow done");
		// Outputs off, external clock positive edge, start enable set
		wr(A_CTL, 8'h88);
		wr(A_ST, 8'hE0);
		go <= 1'b1;
		do @(posedge ref_clk); while (done !== 1'b1);
		go <= 1'b0;
		repeat (6) tick();
		rd(A_SD, 8'h3C, 8'hFF);
		rd(A_ST, 8'hC0, 8'hEF);
		tick();
		chk_bit(sirq, 1'b1);
		wr(A_ST, 8'h80);
		rd(A_ST, 8'h40, 8'hEF);
		$display("test frame done");
		// Toggle strobe counts when strobe select is set with an external source
		wr(A_CTL, 8'h0A);
		wr(A_CTL, 8'h0B);
		rd(A_ST, 8'h41, 8'hEF);
		chk_bit(seen_tog, 1'b1);
		wr(A_CTL, 8'h04);
		@(posedge ref_clk);
		tm <= 1'b1;
		@(posedge ref_clk);
		tm <= 1'b0;
		rd(A_SD, 8'h79, 8'hFF);
		rd(A_ST, 8'h42, 8'hEF);
		$display("test sources done");
		// Two-wire: SDA pulled by MSB zero, SCL held by pending overflow in mode 11
		cdir <= 1'b1;
		cport <= 1'b1;
		ddir <= 1'b1;
		dport <= 1'b1;
		wr(A_CTL, 8'h20);
		tick();
		chk_bit(sda_oe, 1'b1);
		chk_bit(scl_oe, 1'b0);
		wr(A_CTL, 8'h30);
		tick();
		chk_bit(scl_oe, 1'b1);
		wr(A_ST, 8'h40);
		tick();
		chk_bit(scl_oe, 1'b0);
		rd(A_ST, 8'h10, 8'hFF);
		rd(A_RB, 8'h3C, 8'hFF);
		$display("test two-wire done");
		stop_test();
	end
endmodule

`default_nettype wire
